// >>> hw/ipsa_pkg.sv
// Functional notes
// - The pin 3 select word routes its chosen input function to connector pin 3 and resets to 0882.
// - The pin 5 select word routes its chosen input function to connector pin 5 and resets to 0995.
// - The pin 5 select word is ignored while the control-change input is placed on pin 5.
// - The pin 5 select word is ignored while the placement word puts either stroke-end input on pin 5.
// - The pin 6 select word routes its chosen input function to connector pin 6 and resets to 0000.
// - The pin 7 select word routes its chosen input function to connector pin 7 and resets to 0000.
// - The stroke-end placement word overrides stroke-end placements made through the select words.
// - Forward placed on its default pin 6 lets the pin 6 word win; reverse on default pin 7 lets pin 7 win.
// - The lowest placement digit picks the forward pin, the next the reverse pin; the word resets to 0403.
//
// package of the input pin signal assignment block
// assumes a 32-bit AXI4-Lite register bus with byte addresses

package ipsa_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] IPSA_ADDR_PIN3 = 8'h00;
	localparam logic [7:0] IPSA_ADDR_PIN5 = 8'h04;
	localparam logic [7:0] IPSA_ADDR_PIN6 = 8'h08;
	localparam logic [7:0] IPSA_ADDR_PIN7 = 8'h0C;
	localparam logic [7:0] IPSA_ADDR_STROKE = 8'h10;
	localparam logic [7:0] IPSA_ADDR_STATUS = 8'h14;

	localparam logic [15:0] IPSA_RST_PIN3 = 16'h0882;
	localparam logic [15:0] IPSA_RST_PIN5 = 16'h0995;
	localparam logic [15:0] IPSA_RST_PIN6 = 16'h0000;
	localparam logic [15:0] IPSA_RST_PIN7 = 16'h0000;
	localparam logic [15:0] IPSA_RST_STROKE = 16'h0403;

	// ************************************************************
	// field layout
	// ************************************************************
	localparam int IPSA_WORD_W = 16;
	localparam int IPSA_DIGIT_W = 4;
	localparam int IPSA_SPEED_LSB = 0;
	localparam int IPSA_TORQUE_LSB = 4;
	localparam int IPSA_FWD_LSB = 0;
	localparam int IPSA_REV_LSB = 4;
	localparam int IPSA_NUM_FUNC = 16;
	localparam int IPSA_NUM_PINS = 4;

	// pin index in pin_in
	localparam logic [1:0] IPSA_IDX_PIN3 = 2'h0;
	localparam logic [1:0] IPSA_IDX_PIN5 = 2'h1;
	localparam logic [1:0] IPSA_IDX_PIN6 = 2'h2;
	localparam logic [1:0] IPSA_IDX_PIN7 = 2'h3;

	// stroke-end placement digit codes
	localparam logic [3:0] IPSA_PLACE_NONE = 4'h0;
	localparam logic [3:0] IPSA_PLACE_PIN3 = 4'h1;
	localparam logic [3:0] IPSA_PLACE_PIN5 = 4'h2;
	localparam logic [3:0] IPSA_PLACE_PIN6 = 4'h3;
	localparam logic [3:0] IPSA_PLACE_PIN7 = 4'h4;

	// function codes in a select digit
	localparam logic [3:0] IPSA_FUNC_NONE = 4'h0;
	localparam logic [3:0] IPSA_FUNC_FWD_STROKE = 4'hE;
	localparam logic [3:0] IPSA_FUNC_REV_STROKE = 4'hF;

	// status word bit positions
	localparam int IPSA_ST_FWD = 16;
	localparam int IPSA_ST_REV = 17;
	localparam int IPSA_ST_CTRL_CHG = 18;
	localparam int IPSA_ST_EN_LSB = 20;

	// axi responses
	localparam logic [1:0] IPSA_RESP_OKAY = 2'h0;
	localparam logic [1:0] IPSA_RESP_SLVERR = 2'h2;
	localparam logic [1:0] IPSA_RESP_DECERR = 2'h3;

endpackage

// >>> hw/ipsa_pin_decode.sv
// one connector pin: select word digit to function vector
// assumes pin level is active high and synchronous to aclk

`timescale 1ns/100ps

module ipsa_pin_decode
	import ipsa_pkg::*;
(
	input wire logic [IPSA_WORD_W-1:0] sel_word, // select word of this pin
	input wire logic mode_torque, // 1 torque mode, 0 speed mode
	input wire logic word_enable, // word not overridden
	input wire logic pin_level, // pin input level
	output logic [IPSA_NUM_FUNC-1:0] func_vec // functions asserted by this pin
);

	logic [IPSA_DIGIT_W-1:0] code;

	// ************************************************************
	// digit pick and decode
	// ************************************************************
	always_comb
	begin
		code = mode_torque ? sel_word[IPSA_TORQUE_LSB +: IPSA_DIGIT_W]
			: sel_word[IPSA_SPEED_LSB +: IPSA_DIGIT_W];
		func_vec = '0;
		if (word_enable && (code != IPSA_FUNC_NONE) && pin_level)
		begin
			func_vec[code] = 1'b1;
		end
	end

endmodule

// >>> hw/ipsa_top.sv
// input pin signal assignment: select words, stroke-end placement, axi4-lite slave
// assumes pins and mode inputs synchronous to aclk; pin 5 control-change flag from outside

`timescale 1ns/100ps

module ipsa_top
	import ipsa_pkg::*;
(
	input wire logic aclk, // 20 MHz clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic [2:0] s_axi_awprot, // write protection, unused
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic [2:0] s_axi_arprot, // read protection, unused
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [IPSA_NUM_PINS-1:0] pin_in, // pins 3,5,6,7 at index 0..3
	input wire logic mode_torque, // 1 torque mode, 0 speed mode
	input wire logic ctrl_chg_on_pin5, // control change placed on pin 5
	output logic [IPSA_NUM_FUNC-1:0] func_active, // resolved input functions
	output logic forward_stroke_end, // resolved forward stroke end
	output logic reverse_stroke_end, // resolved reverse stroke end
	output logic control_change_input // control change from pin 5
);

	// ************************************************************
	// declarations
	// ************************************************************
	logic [IPSA_WORD_W-1:0] pin3_select_word;
	logic [IPSA_WORD_W-1:0] pin5_select_word;
	logic [IPSA_WORD_W-1:0] pin6_select_word;
	logic [IPSA_WORD_W-1:0] pin7_select_word;
	logic [IPSA_WORD_W-1:0] stroke_end_placement;
	logic [IPSA_WORD_W-1:0] sel_words [IPSA_NUM_PINS];

	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [1:0] next_bresp;

	logic [IPSA_DIGIT_W-1:0] fwd_code;
	logic [IPSA_DIGIT_W-1:0] rev_code;
	logic fwd_valid;
	logic rev_valid;
	logic [1:0] fwd_idx;
	logic [1:0] rev_idx;
	logic fwd_override;
	logic rev_override;
	logic [IPSA_NUM_PINS-1:0] word_enable;
	logic [IPSA_NUM_FUNC-1:0] pin_funcs [IPSA_NUM_PINS];
	logic [IPSA_NUM_FUNC-1:0] next_func;
	logic next_fwd;
	logic next_rev;
	logic next_ctrl_chg;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// ************************************************************
	// placement digit to pin index
	// ************************************************************
	function automatic logic [2:0] place_decode(input logic [IPSA_DIGIT_W-1:0] code);
		logic [2:0] r;
		r = 3'h0;
		case (code)
			IPSA_PLACE_PIN3: r = {1'b1, IPSA_IDX_PIN3};
			IPSA_PLACE_PIN5: r = {1'b1, IPSA_IDX_PIN5};
			IPSA_PLACE_PIN6: r = {1'b1, IPSA_IDX_PIN6};
			IPSA_PLACE_PIN7: r = {1'b1, IPSA_IDX_PIN7};
			default: r = 3'h0;
		endcase
		return r;
	endfunction

	// 16-bit register update under byte strobes
	function automatic logic [IPSA_WORD_W-1:0] merge(input logic [IPSA_WORD_W-1:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [IPSA_WORD_W-1:0] r;
		r = old;
		if (strb[0])
		begin
			r[7:0] = data[7:0];
		end
		if (strb[1])
		begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction

	// ************************************************************
	// axi write channel
	// ************************************************************
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		else if (do_write)
		begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (do_write)
		begin
			w_held <= 1'b0;
		end
	end

	always_comb
	begin
		case (aw_addr)
			IPSA_ADDR_PIN3, IPSA_ADDR_PIN5, IPSA_ADDR_PIN6, IPSA_ADDR_PIN7, IPSA_ADDR_STROKE:
				next_bresp = IPSA_RESP_OKAY;
			IPSA_ADDR_STATUS: next_bresp = IPSA_RESP_SLVERR;
			default: next_bresp = IPSA_RESP_DECERR;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= IPSA_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= next_bresp;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ************************************************************
	// configuration words
	// ************************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin3_select_word <= IPSA_RST_PIN3;
			pin5_select_word <= IPSA_RST_PIN5;
			pin6_select_word <= IPSA_RST_PIN6;
			pin7_select_word <= IPSA_RST_PIN7;
			stroke_end_placement <= IPSA_RST_STROKE;
		end
		else if (do_write)
		begin
			case (aw_addr)
				IPSA_ADDR_PIN3: pin3_select_word <= merge(pin3_select_word, w_data, w_strb);
				IPSA_ADDR_PIN5: pin5_select_word <= merge(pin5_select_word, w_data, w_strb);
				IPSA_ADDR_PIN6: pin6_select_word <= merge(pin6_select_word, w_data, w_strb);
				IPSA_ADDR_PIN7: pin7_select_word <= merge(pin7_select_word, w_data, w_strb);
				IPSA_ADDR_STROKE: stroke_end_placement <= merge(stroke_end_placement, w_data, w_strb);
				default: ;
			endcase
		end
	end

	// ************************************************************
	// stroke-end placement and word enables
	// ************************************************************
	assign fwd_code = stroke_end_placement[IPSA_FWD_LSB +: IPSA_DIGIT_W];
	assign rev_code = stroke_end_placement[IPSA_REV_LSB +: IPSA_DIGIT_W];

	always_comb
	begin
		{fwd_valid, fwd_idx} = place_decode(fwd_code);
		{rev_valid, rev_idx} = place_decode(rev_code);
		// default pin leaves the select word in charge
		fwd_override = fwd_valid && (fwd_code != IPSA_PLACE_PIN6);
		rev_override = rev_valid && (rev_code != IPSA_PLACE_PIN7);
	end

	assign sel_words[IPSA_IDX_PIN3] = pin3_select_word;
	assign sel_words[IPSA_IDX_PIN5] = pin5_select_word;
	assign sel_words[IPSA_IDX_PIN6] = pin6_select_word;
	assign sel_words[IPSA_IDX_PIN7] = pin7_select_word;

	genvar gi;
	generate
		for (gi = 0; gi < IPSA_NUM_PINS; gi++)
		begin : g_pin
			always_comb
			begin
				word_enable[gi] = 1'b1;
				if ((fwd_override && (fwd_idx == 2'(gi))) || (rev_override && (rev_idx == 2'(gi))))
				begin
					word_enable[gi] = 1'b0;
				end
				if ((2'(gi) == IPSA_IDX_PIN5) && ctrl_chg_on_pin5)
				begin
					word_enable[gi] = 1'b0;
				end
			end

			ipsa_pin_decode u_dec (
				.sel_word(sel_words[gi]),
				.mode_torque(mode_torque),
				.word_enable(word_enable[gi]),
				.pin_level(pin_in[gi]),
				.func_vec(pin_funcs[gi])
			);
		end
	endgenerate

	// ************************************************************
	// resolution of functions
	// ************************************************************
	always_comb
	begin
		next_func = '0;
		for (int i = 0; i < IPSA_NUM_PINS; i++)
		begin
			next_func = next_func | pin_funcs[i];
		end
		// placement word beats select-word stroke assignments
		if (fwd_override)
		begin
			next_fwd = pin_in[fwd_idx];
		end
		else
		begin
			next_fwd = next_func[IPSA_FUNC_FWD_STROKE];
		end
		if (rev_override)
		begin
			next_rev = pin_in[rev_idx];
		end
		else
		begin
			next_rev = next_func[IPSA_FUNC_REV_STROKE];
		end
		next_func[IPSA_FUNC_FWD_STROKE] = next_fwd;
		next_func[IPSA_FUNC_REV_STROKE] = next_rev;
		// stroke placement on pin 5 takes the pin from control change
		next_ctrl_chg = ctrl_chg_on_pin5 && word_enable[IPSA_IDX_PIN5] == 1'b0
			&& !((fwd_override && fwd_idx == IPSA_IDX_PIN5) || (rev_override && rev_idx == IPSA_IDX_PIN5))
			&& pin_in[IPSA_IDX_PIN5];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			func_active <= '0;
			forward_stroke_end <= 1'b0;
			reverse_stroke_end <= 1'b0;
			control_change_input <= 1'b0;
		end
		else
		begin
			func_active <= next_func;
			forward_stroke_end <= next_fwd;
			reverse_stroke_end <= next_rev;
			control_change_input <= next_ctrl_chg;
		end
	end

	// ************************************************************
	// axi read channel
	// ************************************************************
	assign s_axi_arready = !s_axi_rvalid;

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		next_rresp = IPSA_RESP_OKAY;
		case (s_axi_araddr)
			IPSA_ADDR_PIN3: next_rdata[IPSA_WORD_W-1:0] = pin3_select_word;
			IPSA_ADDR_PIN5: next_rdata[IPSA_WORD_W-1:0] = pin5_select_word;
			IPSA_ADDR_PIN6: next_rdata[IPSA_WORD_W-1:0] = pin6_select_word;
			IPSA_ADDR_PIN7: next_rdata[IPSA_WORD_W-1:0] = pin7_select_word;
			IPSA_ADDR_STROKE: next_rdata[IPSA_WORD_W-1:0] = stroke_end_placement;
			IPSA_ADDR_STATUS:
			begin
				next_rdata[IPSA_NUM_FUNC-1:0] = func_active;
				next_rdata[IPSA_ST_FWD] = forward_stroke_end;
				next_rdata[IPSA_ST_REV] = reverse_stroke_end;
				next_rdata[IPSA_ST_CTRL_CHG] = control_change_input;
				next_rdata[IPSA_ST_EN_LSB +: IPSA_NUM_PINS] = word_enable;
			end
			default: next_rresp = IPSA_RESP_DECERR;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= IPSA_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
		else if (s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// >>> tb/ipsa_ctrl_model.sv
// model of the motion controller driving connector pins 3,5,6,7
// assumes levels are requested by the bench, one clock of wiring delay

`timescale 1ns/100ps

module ipsa_ctrl_model (
	input wire logic aclk, // clock
	input wire logic [3:0] level, // requested pin levels
	output logic [3:0] pin_in // pins 3,5,6,7
);
	// ************************************************************
	// pin drive
	// ************************************************************
	initial pin_in = 4'h0;
	always @(posedge aclk)
	begin
		pin_in <= level;
	end
endmodule

// >>> tb/ipsa_top_assertions.sv
// checker of the input pin assignment block
// assumes it is bound to ipsa_top and sees only its ports

`timescale 1ns/100ps

module ipsa_chk (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, active low
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [3:0] pin_in, // pin levels
	input wire logic ctrl_chg_on_pin5, // control change on pin 5
	input wire logic [15:0] func_active, // functions
	input wire logic forward_stroke_end, // forward stroke end
	input wire logic reverse_stroke_end, // reverse stroke end
	input wire logic control_change_input // control change
);
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_bit0; func_active[0] == 1'h0; endproperty
	a_bit0: assert property (p_bit0) else $error("function 0 asserted");
	property p_idle;
		pin_in == 4'h0 |=> func_active == 16'h0 && !forward_stroke_end && !reverse_stroke_end && !control_change_input;
	endproperty
	a_idle: assert property (p_idle) else $error("function active with all pins low");
	property p_fwd; func_active[14] == forward_stroke_end; endproperty
	a_fwd: assert property (p_fwd) else $error("forward bit differs");
	property p_rev; func_active[15] == reverse_stroke_end; endproperty
	a_rev: assert property (p_rev) else $error("reverse bit differs");
	property p_ctrl_chg; control_change_input |-> $past(ctrl_chg_on_pin5) && $past(pin_in[1]); endproperty
	a_ctrl_chg: assert property (p_ctrl_chg) else $error("control change without cause");
	property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
	property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
	property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_wr_busy: assert property (p_wr_busy) else $error("write taken while answering");
endmodule

bind ipsa_top ipsa_chk i_ipsa_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .pin_in, .ctrl_chg_on_pin5, .func_active, .forward_stroke_end,
	.reverse_stroke_end, .control_change_input);

// >>> tb/tb_ipsa_top.sv
// bench of the input pin assignment block over axi4-lite
// assumes ipsa_top, ipsa_ctrl_model and the bound checker

`timescale 1ns/100ps

module tb_ipsa_top import ipsa_pkg::*;;
	logic aclk = 1'h0, aresetn = 1'h0, mode_torque = 1'h0, ctrl_chg_on_pin5 = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF, level = 4'h0, pin_in;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] func_active;
	logic forward_stroke_end, reverse_stroke_end, control_change_input;
	logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	logic [15:0] rv [5] = '{16'h0882, 16'h0995, 16'h0000, 16'h0000, 16'h0403};
	int fail_count = 0, num_checks = 0, cyc = 0;

	ipsa_top i_ipsa_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .mode_torque, .ctrl_chg_on_pin5,
		.func_active, .forward_stroke_end, .reverse_stroke_end, .control_change_input);
	ipsa_ctrl_model i_ipsa_ctrl_model (.aclk, .level, .pin_in);

	always #25 aclk = ~aclk;

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic close_out;
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1);
		chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1);
		chk(s_axi_rdata, ed, "rdata");
		chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
	endtask

	// levels pass the model and the design register: three edges
	task automatic pins(input logic [3:0] l, input logic [31:0] e);
		level <= l;
		repeat (3) @(posedge aclk);
		chk({13'h0, control_change_input, reverse_stroke_end, forward_stroke_end, func_active}, e, "outputs");
	endtask

	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			close_out;
		end
	end

	// ************************************************************
	// tests
	// ************************************************************
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		for (int i = 0; i < 5; i++)
			rd(ra[i], {16'h0, rv[i]}, IPSA_RESP_OKAY);
		rd(8'h18, 32'h0, IPSA_RESP_DECERR);
		wr(IPSA_ADDR_STATUS, 32'h0, IPSA_RESP_SLVERR);
		wr(IPSA_ADDR_PIN3, 32'hABCD0882, IPSA_RESP_OKAY);
		rd(IPSA_ADDR_PIN3, 32'h00000882, IPSA_RESP_OKAY);
		pins(4'h1, 32'h00000004);
		pins(4'h2, 32'h00000020);
		mode_torque <= 1'h1;
		pins(4'h3, 32'h00000300);
		mode_torque <= 1'h0;
		ctrl_chg_on_pin5 <= 1'h1;
		pins(4'h2, 32'h00040000);
		ctrl_chg_on_pin5 <= 1'h0;
		pins(4'h0, 32'h00000000);
		for (int k = 1; k < 14; k++)
		begin
			wr(IPSA_ADDR_PIN6, 32'(k), IPSA_RESP_OKAY);
			pins(4'h4, 32'h1 << k);
		end
		wr(IPSA_ADDR_PIN7, 32'h0000000D, IPSA_RESP_OKAY);
		pins(4'h8, 32'h00002000);
		wr(IPSA_ADDR_PIN6, 32'h0000000E, IPSA_RESP_OKAY);
		wr(IPSA_ADDR_PIN7, 32'h0000000F, IPSA_RESP_OKAY);
		pins(4'hC, 32'h0003C000);
		wr(IPSA_ADDR_STROKE, 32'h00000042, IPSA_RESP_OKAY);
		ctrl_chg_on_pin5 <= 1'h1;
		pins(4'h6, 32'h00014000);
		ctrl_chg_on_pin5 <= 1'h0;
		wr(IPSA_ADDR_STROKE, 32'h00000012, IPSA_RESP_OKAY);
		// pin 5 high: its own word must stay off without the control change
		pins(4'hB, 32'h0003C000);
		rd(IPSA_ADDR_STATUS, 32'h00C3C000, IPSA_RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		wr(IPSA_ADDR_PIN5, 32'h0000FF12, IPSA_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(IPSA_ADDR_PIN5, 32'h00000912, IPSA_RESP_OKAY);
		close_out;
	end
endmodule
